// [dps_sequencer.sv]
// two-channel supply switch sequencer with breaker and power-good reset
`default_nettype none

// Functional notes
// - enable start needs supplies above lockout, no breaker
// - timer done turns charge pump on
// - feedback good, one timing cycle, then release reset
// - enable between 0.4V and 0.8V ramps both down
// - feedback low drives reset low at once
// - enable mid level: timer, then channel one only
// - enable above 2V ramps channel two at once
// - enable between 0.8V and 2V ramps channel two down
// - enable below 0.4V clamps both gates to ground
// - spare output follows 1.238V comparator
// - qualified sense fault latches breaker, clamps both gates
// - short feedback good keeps reset low, restarts wait
module dps_sequencer #(
  parameter int unsigned TIMER_CYCLES = dps_pkg::TIMER_CYCLES_DEF
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic enable_above_low,
  input wire logic enable_above_mid,
  input wire logic enable_above_high,
  input wire logic primary_supply,
  input wire logic secondary_supply,
  input wire logic sense_overcurrent,
  input wire logic feedback_monitor_input,
  input wire logic spare_compare_input,
  output logic channel_one_drive,
  output logic channel_one_clamp,
  output logic channel_two_drive,
  output logic channel_two_clamp,
  output logic system_reset_n,
  output logic spare_compare_output,
  output logic breaker_latched,
  output logic timer_running
);

  // ---------------------------------------------------------------
  // input synchronisation
  // ---------------------------------------------------------------
  logic [dps_pkg::NUM_IN-1:0] raw_in; // comparator levels from the pins
  logic [dps_pkg::NUM_IN-1:0] cmp;    // same levels, on sys_clk

  assign raw_in[dps_pkg::IN_EN_LOW] = enable_above_low;
  assign raw_in[dps_pkg::IN_EN_MID] = enable_above_mid;
  assign raw_in[dps_pkg::IN_EN_HIGH] = enable_above_high;
  assign raw_in[dps_pkg::IN_PRIMARY] = primary_supply;
  assign raw_in[dps_pkg::IN_SECONDARY] = secondary_supply;
  assign raw_in[dps_pkg::IN_SENSE] = sense_overcurrent;
  assign raw_in[dps_pkg::IN_FEEDBACK] = feedback_monitor_input;
  assign raw_in[dps_pkg::IN_SPARE] = spare_compare_input;

  // every threshold crossing passes two flops first
  dps_sync #(
    .W(dps_pkg::NUM_IN)
  ) u_sync (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .async_in(raw_in),
    .sync_out(cmp)
  );

  // ---------------------------------------------------------------
  // decoded levels
  // ---------------------------------------------------------------
  logic en_low;       // enable above 0.4 V
  logic en_mid;       // enable above 0.8 V
  logic en_high;      // enable above 2 V
  logic supplies_ok;  // both supplies above lockout
  logic feedback_good; // monitored output is good

  assign en_low = cmp[dps_pkg::IN_EN_LOW];
  assign en_mid = cmp[dps_pkg::IN_EN_MID];
  assign en_high = cmp[dps_pkg::IN_EN_HIGH];
  assign supplies_ok = cmp[dps_pkg::IN_PRIMARY] & cmp[dps_pkg::IN_SECONDARY];
  assign feedback_good = cmp[dps_pkg::IN_FEEDBACK];

  // ---------------------------------------------------------------
  // circuit breaker
  // ---------------------------------------------------------------
  logic [dps_pkg::BREAKER_CW-1:0] fault_count; // cycles the sense fault has persisted
  logic fault_trip;                            // fault has lasted the filter time

  localparam logic [dps_pkg::BREAKER_CW-1:0] FAULT_LAST =
    dps_pkg::BREAKER_CW'(dps_pkg::BREAKER_CYCLES - 1);

  // persistence filter, restarts on any quiet cycle
  always_ff @(posedge sys_clk) begin
    if (!rstn || !cmp[dps_pkg::IN_SENSE]) begin
      fault_count <= '0;
    end else if (fault_count != FAULT_LAST) begin
      fault_count <= fault_count + dps_pkg::BREAKER_CW'(1);
    end
  end

  assign fault_trip = cmp[dps_pkg::IN_SENSE] && (fault_count == FAULT_LAST);

  // latch: trip sets, enable below 0.4 V clears, set wins
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      breaker_latched <= 1'b0;
    end else if (fault_trip) begin
      breaker_latched <= 1'b1;
    end else if (!en_low) begin
      breaker_latched <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // turn-on sequencer
  // ---------------------------------------------------------------
  dps_pkg::dps_seq_type seq_state;      // current sequencer state
  dps_pkg::dps_seq_type next_seq_state; // state for the next edge
  logic on_timer_done;                  // turn-on timer has completed
  logic start_ok;                       // conditions to begin a timer cycle

  assign start_ok = en_mid && supplies_ok && !breaker_latched && !fault_trip;

  // turn-on delay timer runs only in the wait state
  dps_timer #(
    .CYCLES(TIMER_CYCLES)
  ) u_on_timer (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .run(seq_state == dps_pkg::seq_wait),
    .expired(on_timer_done)
  );

  // next state decode
  always_comb begin
    next_seq_state = seq_state;
    case (seq_state)
      dps_pkg::seq_off: begin
        // enable up with supplies good and no breaker: start timer
        if (start_ok) begin
          next_seq_state = dps_pkg::seq_wait;
        end
      end
      dps_pkg::seq_wait: begin
        // any loss of conditions abandons the cycle
        if (!start_ok) begin
          next_seq_state = dps_pkg::seq_off;
        end else if (on_timer_done) begin
          next_seq_state = dps_pkg::seq_on;
        end
      end
      dps_pkg::seq_on: begin
        // enable below 0.8 V, lockout or breaker stops the pump
        if (!start_ok) begin
          next_seq_state = dps_pkg::seq_off;
        end
      end
      default: begin
        next_seq_state = dps_pkg::seq_off;
      end
    endcase
  end

  // state register
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      seq_state <= dps_pkg::seq_off;
    end else begin
      seq_state <= next_seq_state;
    end
  end

  // ---------------------------------------------------------------
  // gate drives
  // ---------------------------------------------------------------
  logic next_clamp;     // both gates pulled to ground
  logic next_one_drive; // channel one ramps up
  logic next_two_drive; // channel two ramps up

  // clamp beats ramp; neither drive nor clamp means ramp down
  always_comb begin
    next_clamp = !en_low || breaker_latched || fault_trip;
    // channel one needs the pump and enable above 0.8 V
    next_one_drive = !next_clamp && (next_seq_state == dps_pkg::seq_on);
    // channel two follows enable above 2 V with no extra delay
    next_two_drive = next_one_drive && en_high;
  end

  // drive outputs registered
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      channel_one_drive <= 1'b0;
      channel_two_drive <= 1'b0;
      channel_one_clamp <= 1'b1;
      channel_two_clamp <= 1'b1;
    end else begin
      channel_one_drive <= next_one_drive;
      channel_two_drive <= next_two_drive;
      channel_one_clamp <= next_clamp;
      channel_two_clamp <= next_clamp;
    end
  end

  // timer activity flag for status
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      timer_running <= 1'b0;
    end else begin
      timer_running <= (next_seq_state == dps_pkg::seq_wait);
    end
  end

  // ---------------------------------------------------------------
  // power-good reset monitor
  // ---------------------------------------------------------------
  logic pg_done; // feedback good for one full timing cycle

  // timer restarts from zero whenever feedback drops
  dps_timer #(
    .CYCLES(TIMER_CYCLES)
  ) u_pg_timer (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .run(feedback_good),
    .expired(pg_done)
  );

  // release only after the full cycle, pull low on feedback loss
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      system_reset_n <= 1'b0;
    end else begin
      system_reset_n <= feedback_good && pg_done;
    end
  end

  // ---------------------------------------------------------------
  // spare comparator
  // ---------------------------------------------------------------
  // output follows the reference comparison
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      spare_compare_output <= 1'b0;
    end else begin
      spare_compare_output <= cmp[dps_pkg::IN_SPARE];
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  // timer start from off needs enable, supplies and no breaker
  sequence s_start_seen;
    seq_state == dps_pkg::seq_off ##1 seq_state == dps_pkg::seq_wait;
  endsequence

  a_start_gate: assert property (
    s_start_seen |-> $past(supplies_ok) && $past(en_mid) && !$past(breaker_latched))
    else $error("timer started without enable, supplies or with breaker");

  a_pump_on_timer: assert property (
    $rose(seq_state == dps_pkg::seq_on) |-> $past(on_timer_done))
    else $error("pump turned on before timer done");

  a_reset_after_cycle: assert property (
    $rose(system_reset_n) |-> $past(pg_done) && $past(feedback_good))
    else $error("reset released without full good cycle");

  a_ramp_down_mid: assert property (
    en_low && !en_mid |=> !channel_one_drive && !channel_two_drive)
    else $error("drive held with enable below 0.8V");

  a_reset_drop: assert property (
    !feedback_good |=> !system_reset_n)
    else $error("reset not low after feedback loss");

  a_two_needs_high: assert property (
    channel_two_drive |-> channel_one_drive && $past(en_high))
    else $error("channel two driving without enable above 2V");

  a_two_at_once: assert property (
    seq_state == dps_pkg::seq_on && $rose(en_high) && start_ok && !next_clamp
      |=> channel_two_drive)
    else $error("channel two delayed after enable above 2V");

  a_low_clamp: assert property (
    !en_low |=> channel_one_clamp && channel_two_clamp && !channel_one_drive)
    else $error("gates not clamped below 0.4V");

  a_spare_follow: assert property (
    ##1 spare_compare_output == $past(cmp[dps_pkg::IN_SPARE]))
    else $error("spare output does not follow comparator");

  a_breaker_trip: assert property (
    fault_trip |=> breaker_latched ##0 channel_one_clamp ##1 channel_two_clamp)
    else $error("breaker did not latch or clamp");

  a_breaker_hold: assert property (
    breaker_latched && en_low && !fault_trip |=> breaker_latched)
    else $error("breaker cleared while enable above 0.4V");

  a_short_good: assert property (
    $rose(feedback_good) |-> !system_reset_n [*2])
    else $error("reset released on short good pulse");

endmodule // dps_sequencer

`default_nettype wire

// [dps_pkg.sv]
// shared constants and types for the dual channel power sequencer
`default_nettype none

package dps_pkg;

  // ---------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 5;             // sys_clk at 200 MHz
  localparam int TIMER_PERIOD_NS = 200_000_000; // default timer cycle, 200 ms
  // longest time, rounded down, at least one cycle
  localparam int TIMER_CYCLES_DEF = (TIMER_PERIOD_NS / CLK_PERIOD_NS < 1) ? 1 :
                                    TIMER_PERIOD_NS / CLK_PERIOD_NS;
  localparam int BREAKER_FILTER_NS = 1500;      // sense fault must persist this long
  // least time, rounded up
  localparam int BREAKER_CYCLES = (BREAKER_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BREAKER_CW = $clog2(BREAKER_CYCLES + 1);

  // ---------------------------------------------------------------
  // comparator input vector layout
  // ---------------------------------------------------------------
  localparam int IN_EN_LOW = 0;      // enable above 0.4 V
  localparam int IN_EN_MID = 1;      // enable above 0.8 V
  localparam int IN_EN_HIGH = 2;     // enable above 2 V
  localparam int IN_PRIMARY = 3;     // primary supply above 2.23 V
  localparam int IN_SECONDARY = 4;   // secondary supply above 1.12 V
  localparam int IN_SENSE = 5;       // sense drop above 50 mV
  localparam int IN_FEEDBACK = 6;    // feedback above 1.238 V
  localparam int IN_SPARE = 7;       // spare input above 1.238 V
  localparam int NUM_IN = 8;

  // ---------------------------------------------------------------
  // turn-on sequencer states
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    seq_off = 2'b00,   // charge pump off, gates ramp down or clamped
    seq_wait = 2'b01,  // turn-on timer cycle running
    seq_on = 2'b10     // charge pump on
  } dps_seq_type;

endpackage : dps_pkg

`default_nettype wire

// [dps_sync.sv]
// two flip-flop synchroniser for a vector of comparator levels
`default_nettype none

module dps_sync #(
  parameter int W = 1
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  // ---------------------------------------------------------------
  // capture stages
  // ---------------------------------------------------------------
  logic [W-1:0] stage_one; // read only by the second stage

  // two stages, reset to all low
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      stage_one <= '0;
      sync_out <= '0;
    end else begin
      stage_one <= async_in;
      sync_out <= stage_one;
    end
  end

endmodule // dps_sync

`default_nettype wire

// [dps_timer.sv]
// timing cycle counter: runs while enabled, flags a completed cycle
`default_nettype none

module dps_timer #(
  parameter int unsigned CYCLES = 4
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic run,
  output logic expired
);

  // ---------------------------------------------------------------
  // counter
  // ---------------------------------------------------------------
  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);
  logic [CW-1:0] count; // cycles spent while running

  // count up while run, restart from zero whenever run drops
  always_ff @(posedge sys_clk) begin
    if (!rstn || !run) begin
      count <= '0;
    end else if (!expired) begin
      count <= count + CW'(1);
    end
  end

  // expired holds once a full cycle has passed, until run drops
  always_ff @(posedge sys_clk) begin
    if (!rstn || !run) begin
      expired <= 1'b0;
    end else if (count == LAST) begin
      expired <= 1'b1;
    end
  end

endmodule // dps_timer

`default_nettype wire

// [dps_host_model.sv]
// host side model: enable level source and consumer of the system reset
`default_nettype none

module dps_host_model (
  input wire logic sys_clk,
  input wire logic [1:0] level,
  input wire logic system_reset_n,
  output logic enable_above_low,
  output logic enable_above_mid,
  output logic enable_above_high,
  output logic [7:0] releases
);
  timeunit 1ns;
  timeprecision 1ps;

  logic last_rst_n; // reset level one edge ago

  // ---------------------------------------------------------------
  // enable level
  // ---------------------------------------------------------------
  // one analog level: a higher threshold always implies the lower ones
  assign enable_above_low = (level != 2'h0);
  assign enable_above_mid = (level >= 2'h2);
  assign enable_above_high = (level == 2'h3);

  // ---------------------------------------------------------------
  // reset consumer
  // ---------------------------------------------------------------
  initial begin
    releases = 8'h00;
    last_rst_n = 1'b0;
  end

  // count each release of the system out of reset
  always @(posedge sys_clk) begin
    last_rst_n <= system_reset_n;
    if (system_reset_n === 1'b1 && last_rst_n === 1'b0) begin
      releases <= releases + 8'h01;
    end
  end
endmodule // dps_host_model

`default_nettype wire

// [dps_sequencer_tb_top.sv]
// self-checking bench for the dual channel power sequencer
`default_nettype none

module dps_sequencer_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  // ---------------------------------------------------------------
  // setup
  // ---------------------------------------------------------------
  localparam int unsigned TC = 10; // shortened timer cycle
  localparam logic [7:0] B_C1D = 8'h80; // output vector bit positions
  localparam logic [7:0] B_C1C = 8'h40;
  localparam logic [7:0] B_C2D = 8'h20;
  localparam logic [7:0] B_C2C = 8'h10;
  localparam logic [7:0] B_RST = 8'h08;
  localparam logic [7:0] B_SPR = 8'h04;
  localparam logic [7:0] B_BRK = 8'h02;
  localparam logic [7:0] B_TMR = 8'h01;
  localparam logic [7:0] B_GATES = 8'hf0; // all four gate outputs

  typedef struct packed {
    logic [7:0] mask;
    logic [7:0] exp;
  } dps_note_type;

  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic [1:0] level = 2'h0; // requested enable level
  logic primary = 1'b0;
  logic secondary = 1'b0;
  logic sense = 1'b0;
  logic feedback = 1'b0;
  logic spare_in = 1'b0;
  logic en_low, en_mid, en_high;
  logic c1d, c1c, c2d, c2c, rst_n, spr, brk, tmr;
  logic [7:0] releases; // reset releases seen by the host
  logic [7:0] outv; // packed outputs
  logic [31:0] seed = 32'h0000fbc8;
  dps_note_type notes[$]; // expected results, oldest first
  dps_note_type cur;
  int n_errors = 0;
  int checks = 0;

  assign outv = {c1d, c1c, c2d, c2c, rst_n, spr, brk, tmr};

  always #2.5 sys_clk = ~sys_clk;

  dps_host_model host (.sys_clk(sys_clk), .level(level), .system_reset_n(rst_n),
    .enable_above_low(en_low), .enable_above_mid(en_mid),
    .enable_above_high(en_high), .releases(releases));

  dps_sequencer #(.TIMER_CYCLES(TC)) uut (.sys_clk(sys_clk), .rstn(rstn),
    .enable_above_low(en_low), .enable_above_mid(en_mid),
    .enable_above_high(en_high), .primary_supply(primary),
    .secondary_supply(secondary), .sense_overcurrent(sense),
    .feedback_monitor_input(feedback), .spare_compare_input(spare_in),
    .channel_one_drive(c1d), .channel_one_clamp(c1c), .channel_two_drive(c2d),
    .channel_two_clamp(c2c), .system_reset_n(rst_n), .spare_compare_output(spr),
    .breaker_latched(brk), .timer_running(tmr));

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // next pseudo random state
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // compare two values and count the outcome
  task automatic check_val(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // wait n falling edges
  task automatic step(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  // note an expected output pattern for the monitor
  task automatic note(input logic [7:0] mask, input logic [7:0] exp);
    notes.push_back('{mask: mask, exp: exp});
  endtask

  // print the counts and the verdict, then stop
  task automatic final_report;
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // monitor: oldest note against the settled outputs
  always @(posedge sys_clk) begin
    if (notes.size() > 0) begin
      cur = notes.pop_front();
      check_val(outv & cur.mask, cur.exp & cur.mask);
    end
  end

  // watchdog: a hang counts as a mismatch
  initial begin
    repeat (20000) @(posedge sys_clk);
    check_val(8'h00, 8'h01);
    final_report();
  end

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  initial begin
    step(8);
    rstn = 1'b1;
    step(1);
    note(8'hff, B_C1C | B_C2C);
    // start refused while either supply is under lockout
    level = 2'h2;
    for (int i = 0; i < 2; i++) begin
      primary = i[0];
      secondary = ~i[0];
      step(TC + 6);
      note(B_TMR | B_C1D, 8'h00);
    end
    // mid level: timer, then channel one only
    primary = 1'b1;
    secondary = 1'b1;
    step(3);
    note(B_TMR | B_C1D | B_C1C, B_TMR);
    step(TC - 1);
    note(B_C1D, 8'h00);
    step(4);
    note(B_GATES, B_C1D);
    // high level: channel two at once
    level = 2'h3;
    step(2);
    note(B_C2D, 8'h00);
    step(1);
    note(B_GATES, B_C1D | B_C2D);
    // short good pulse keeps reset low, next rise waits a full cycle
    feedback = 1'b1;
    step(TC - 4);
    feedback = 1'b0;
    step(TC);
    note(B_RST, 8'h00);
    feedback = 1'b1;
    step(TC + 1);
    note(B_RST, 8'h00);
    step(5);
    note(B_RST, B_RST);
    check_val(releases, 8'h01);
    feedback = 1'b0;
    step(2);
    note(B_RST, B_RST);
    step(1);
    note(B_RST, 8'h00);
    // stepping down the enable level
    level = 2'h2;
    step(3);
    note(B_GATES, B_C1D);
    level = 2'h1;
    step(3);
    note(B_GATES, 8'h00);
    level = 2'h0;
    step(3);
    note(B_GATES, B_C1C | B_C2C);
    // a brief sense fault does not trip
    level = 2'h3;
    sense = 1'b1;
    step(100);
    sense = 1'b0;
    step(TC + 6);
    note(B_BRK | B_C1D | B_C2D, B_C1D | B_C2D);
    // a held fault trips and clamps
    sense = 1'b1;
    step(290);
    note(B_BRK | B_C1D, B_C1D);
    step(16);
    note(B_BRK | B_GATES, B_BRK | B_C1C | B_C2C);
    sense = 1'b0;
    // dipping only to the low band does not clear the breaker
    level = 2'h1;
    step(3);
    level = 2'h3;
    step(TC + 6);
    note(B_BRK | B_C1D | B_TMR, B_BRK);
    // full clear then a fresh start
    level = 2'h0;
    step(4);
    note(B_BRK, 8'h00);
    level = 2'h3;
    step(TC + 6);
    note(B_BRK | B_C1D | B_C2D, B_C1D | B_C2D);
    // spare comparator follows its input
    for (int i = 0; i < 8; i++) begin
      seed = lfsr_next(seed);
      spare_in = seed[0];
      step(3);
      note(B_SPR, {5'h00, seed[0], 2'h0});
    end
    // reset in mid run
    rstn = 1'b0;
    step(8);
    note(8'hff, B_C1C | B_C2C);
    rstn = 1'b1;
    // first edge after release still shows the reset pattern
    step(1);
    note(8'hff, B_C1C | B_C2C);
    // levels reach logic two edges later: timer starts, clamps lift
    step(2);
    note(B_TMR | B_BRK | B_GATES, B_TMR);
    // one timing cycle later both channels ramp
    step(TC + 2);
    note(B_GATES, B_C1D | B_C2D);
    step(2);
    final_report();
  end
endmodule // dps_sequencer_tb_top

`default_nettype wire
